// >>> src/saved_status_capture_restore.sv
// Saved status capture, restore and system register access
`timescale 1ns/10ps
`include "saved_status_defines.svh"
module saved_status_capture_restore
  import saved_status_pkg::*;
#(
  parameter bit HAVE_MONITOR = 1'b1,
  parameter bit HAVE_NARROW = 1'b1,
  parameter bit HAVE_STORE_BYPASS_FLAG = 1'b1,
  parameter bit HAVE_PAN = 1'b1,
  parameter bit HAVE_BIG_ENDIAN = 1'b1,
  parameter bit HAVE_LITTLE_ENDIAN = 1'b1,
  parameter bit HAVE_HYP_LEVEL = 1'b1
)(
  input wire logic clk,
  input wire logic rst_n,
  // Exception entry
  input wire logic entry_valid,
  input wire logic entry_to_mon,
  input wire logic entry_from_narrow,
  input wire logic [4:0] cur_nzcvq,
  input wire logic [7:0] cur_cond_block,
  input wire logic [3:0] cur_greater_equal,
  input wire logic cur_store_bypass,
  input wire logic cur_priv_access_never,
  input wire logic cur_single_step,
  input wire logic cur_illegal_state,
  input wire logic cur_endian,
  input wire logic cur_thumb,
  input wire logic [3:0] cur_masks,
  input wire logic [1:0] cur_level,
  input wire logic cur_stack_sel,
  input wire logic [3:0] cur_narrow_mode,
  // Exception return
  input wire logic return_valid,
  input wire logic return_from_mon,
  output logic [63:0] restore_word,
  output logic restore_narrow,
  output logic restore_illegal,
  // System register access
  input wire logic sysreg_valid,
  input wire logic sysreg_write,
  input wire logic [1:0] sysreg_op0,
  input wire logic [2:0] sysreg_op1,
  input wire logic [3:0] sysreg_crn,
  input wire logic [3:0] sysreg_crm,
  input wire logic [2:0] sysreg_op2,
  input wire logic [63:0] sysreg_wdata,
  input wire logic host_mode_control,
  input wire logic [63:0] supervisor_saved_status,
  output logic supervisor_wr,
  output logic [63:0] supervisor_wdata,
  output logic [63:0] sysreg_rdata,
  output logic sysreg_undef
);

  // Refuse configurations the capture and restore paths cannot serve
  if (!HAVE_BIG_ENDIAN && !HAVE_LITTLE_ENDIAN)
  begin : g_no_endian
    $error("At least one endianness must be supported");
  end

  // A kept bit above the low half would break reserved read-as-zero
  if ((`HYP_KEEP_MASK & ~`LOW_HALF_MASK) != 64'h0000_0000_0000_0000)
  begin : g_keep_mask
    $error("Hyp keep mask reaches the reserved upper half");
  end

  //////////////////////////////////////////////////////////////////////////
  // Entry capture layouts

  logic [63:0] hyp_wide_word;
  logic [63:0] mon_narrow_word;
  logic [63:0] mon_wide_word;
  logic [63:0] hyp_saved_status_q;
  logic [63:0] monitor_saved_status_q;
  logic mon_narrow_q;
  level_t cur_lvl;
  logic lvl_hi;
  assign cur_lvl = level_t'(cur_level);
  // Levels 2 and 3 both reach the hyp word under its own name
  assign lvl_hi = cur_lvl == LVL2 || cur_lvl == LVL3;

  function automatic logic fix_endian(input logic e);
    fix_endian = !HAVE_BIG_ENDIAN ? 1'b0 :
      (!HAVE_LITTLE_ENDIAN ? 1'b1 : e);
  endfunction

  // Reserved positions are left zero by construction
  always_comb
  begin
    hyp_wide_word = 64'h0000_0000_0000_0000;
    hyp_wide_word[`B_N -: 4] = cur_nzcvq[4:1];
    hyp_wide_word[`B_PAN] = HAVE_PAN & cur_priv_access_never;
    hyp_wide_word[`B_SS] = cur_single_step;
    hyp_wide_word[`B_IL] = cur_illegal_state;
    hyp_wide_word[`B_SSBS64] = HAVE_STORE_BYPASS_FLAG & cur_store_bypass;
    hyp_wide_word[`B_D -: 4] = cur_masks;
    hyp_wide_word[`B_NRW] = 1'b0;
    hyp_wide_word[`B_M + 3 -: 2] = cur_level;
    hyp_wide_word[`B_M + 1] = 1'b0;
    hyp_wide_word[`B_M] = cur_stack_sel;
  end

  always_comb
  begin
    mon_narrow_word = 64'h0000_0000_0000_0000;
    mon_narrow_word[`B_N -: 5] = cur_nzcvq;
    mon_narrow_word[`B_IT_LO +: 2] = cur_cond_block[1:0];
    mon_narrow_word[`B_IT_HI +: 6] = cur_cond_block[7:2];
    mon_narrow_word[`B_SSBS32] = HAVE_STORE_BYPASS_FLAG & cur_store_bypass;
    mon_narrow_word[`B_PAN] = HAVE_PAN & cur_priv_access_never;
    mon_narrow_word[`B_SS] = cur_single_step;
    mon_narrow_word[`B_IL] = cur_illegal_state;
    mon_narrow_word[`B_GE +: 4] = cur_greater_equal;
    mon_narrow_word[`B_E] = fix_endian(cur_endian);
    mon_narrow_word[`B_A -: 3] = cur_masks[2:0];
    mon_narrow_word[`B_T] = cur_thumb;
    mon_narrow_word[`B_NRW] = 1'b1;
    mon_narrow_word[`B_M +: 4] = cur_narrow_mode;
  end

  // Monitor wide layout mirrors the hyp one
  assign mon_wide_word = hyp_wide_word;

  //////////////////////////////////////////////////////////////////////////
  // Access decode

  logic enc_base;
  target_t tgt;
  always_comb
  begin
    enc_base = sysreg_op0 == `OP0_SYS && sysreg_crn == `CRN_SPSR &&
      sysreg_crm == `CRM_SPSR && sysreg_op2 == `OP2_SPSR;
    tgt = TGT_NONE;
    if (sysreg_valid && enc_base)
    begin
      case (sysreg_op1)
        `OP1_HYP:
          if (lvl_hi)
            tgt = TGT_HYP;
        `OP1_SUP:
          if (cur_lvl == LVL2 && host_mode_control)
            tgt = TGT_HYP;
          else if (cur_lvl != LVL0)
            tgt = TGT_SUP;
        `OP1_MON:
          if (HAVE_MONITOR && cur_lvl == LVL3)
            tgt = TGT_MON;
        default:
          tgt = TGT_NONE;
      endcase
    end
  end

  // Refused accesses drive zero read data and raise no write strobe
  logic access_hit;
  assign access_hit = sysreg_valid && enc_base &&
    (sysreg_op1 == `OP1_HYP || sysreg_op1 == `OP1_SUP ||
     sysreg_op1 == `OP1_MON);
  assign sysreg_undef = access_hit && tgt == TGT_NONE;
  assign supervisor_wr = sysreg_write && tgt == TGT_SUP;
  assign supervisor_wdata = sysreg_wdata;

  always_comb
  begin
    case (tgt)
      TGT_HYP: sysreg_rdata = hyp_saved_status_q;
      TGT_MON: sysreg_rdata = monitor_saved_status_q;
      TGT_SUP: sysreg_rdata = supervisor_saved_status;
      default: sysreg_rdata = 64'h0000_0000_0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Saved words; reset only for a clean start, value has no meaning

  logic hyp_sw_wr;
  logic mon_sw_wr;
  assign hyp_sw_wr = sysreg_write && tgt == TGT_HYP;
  assign mon_sw_wr = sysreg_write && tgt == TGT_MON;

  // Software writes to the hyp word cannot set reserved bits or bit 4 without narrow support
  logic [63:0] hyp_wmask;
  assign hyp_wmask = HAVE_NARROW ? `HYP_KEEP_MASK :
    (`HYP_KEEP_MASK & ~(64'h0000_0000_0000_0001 << `B_NRW));

  // A narrow image written by software keeps its upper half clear; a
  // wide image is stored as written
  logic [63:0] mon_wdata;
  always_comb
  begin
    if (HAVE_NARROW && sysreg_wdata[`B_NRW])
      mon_wdata = sysreg_wdata & `LOW_HALF_MASK;
    else
      mon_wdata = sysreg_wdata;
  end

  // Narrow entries to hyp leave the word alone; that layout is not held
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hyp_saved_status_q <= 64'h0000_0000_0000_0000;
    else if (entry_valid && !entry_to_mon && !entry_from_narrow)
      hyp_saved_status_q <= hyp_wide_word;
    else if (hyp_sw_wr)
      hyp_saved_status_q <= sysreg_wdata & hyp_wmask;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      monitor_saved_status_q <= 64'h0000_0000_0000_0000;
    else if (!HAVE_MONITOR)
      monitor_saved_status_q <= 64'h0000_0000_0000_0000;
    else if (entry_valid && entry_to_mon)
      monitor_saved_status_q <= entry_from_narrow ? mon_narrow_word :
        mon_wide_word;
    else if (return_valid && return_from_mon && !mon_narrow_q)
      monitor_saved_status_q <= 64'h0000_0000_0000_0000;
    else if (mon_sw_wr)
      monitor_saved_status_q <= mon_wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mon_narrow_q <= 1'b0;
    else if (entry_valid && entry_to_mon)
      mon_narrow_q <= entry_from_narrow;
  end

  //////////////////////////////////////////////////////////////////////////
  // Return: registered restore image and legality

  logic [63:0] ret_src;
  logic [3:0] ret_m;
  logic ret_nrw;
  logic wide_bad;
  logic narrow_bad;
  logic ret_bad;
  always_comb
  begin
    ret_src = return_from_mon ? monitor_saved_status_q : hyp_saved_status_q;
    ret_m = ret_src[`B_M +: 4];
    ret_nrw = HAVE_NARROW & ret_src[`B_NRW];
  end

  // Level 3 codes only make sense when leaving the monitor level
  always_comb
  begin
    case (ret_m)
      `SP_L0, `SP_L1_SHARED, `SP_L1_OWN: wide_bad = 1'b0;
      `SP_L2_SHARED, `SP_L2_OWN: wide_bad = !HAVE_HYP_LEVEL;
      `SP_L3_SHARED, `SP_L3_OWN: wide_bad = !return_from_mon;
      default: wide_bad = 1'b1;
    endcase
  end

  always_comb
  begin
    case (ret_m)
      `MODE_USR, `MODE_FIQ, `MODE_IRQ, `MODE_SVC, `MODE_ABT, `MODE_UND,
      `MODE_SYS: narrow_bad = 1'b0;
      `MODE_HYP: narrow_bad = !HAVE_HYP_LEVEL;
      `MODE_MON: narrow_bad = !HAVE_MONITOR;
      default: narrow_bad = 1'b1;
    endcase
  end

  assign ret_bad = ret_nrw ? narrow_bad : wide_bad;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      restore_word <= 64'h0000_0000_0000_0000;
    else if (return_valid)
    begin
      restore_word <= ret_src;
      // Bit 9 is the debug mask in a wide image; fix endianness only narrow
      if (ret_nrw)
        restore_word[`B_E] <= fix_endian(ret_src[`B_E]);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      restore_narrow <= 1'b0;
    else if (return_valid)
      restore_narrow <= ret_nrw;
  end

  // One-cycle pulse; the sequencer samples it with the restored image
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      restore_illegal <= 1'b0;
    else
      restore_illegal <= return_valid & ret_bad;
  end

endmodule

// >>> common/saved_status_defines.svh
// Bit positions, encodings and access codes of the saved status words
// Contract
// - Hyp 64-bit entry saves illegal flag bit 20, step bit 21; restores them
// - Hyp 64-bit store bypass at bit 12 when present, else zero
// - Hyp 64-bit masks: debug 9, serror 8, irq 7, fiq 6 saved and restored
// - Entry from 64-bit writes bit 4 zero; fixed zero without 32-bit support (monitor word keeps a written bit 4)
// - Hyp level/stack codes 0000, 0100, 0101, 1000, 1001
// - Hyp return with reserved or unimplemented level code is illegal
// - Bits 3:2 from level, bit 0 from stack select; bit 1 zero
// - Read of hyp encoding returns hyp word at levels 2, 3; else undefined
// - Write of hyp encoding loads hyp word at levels 2, 3; else undefined
// - Supervisor read: undefined at 0, redirected to hyp at 2 with host mode
// - Supervisor write: undefined at 0, hyp at 2 with host mode, else sup
// - Monitor word exists only with level 3; else accesses undefined
// - Monitor word 64 bits; upper half zero for 32-bit state
// - Monitor 32-bit: flags N Z C V Q in bits 31 to 27
// - Monitor 32-bit: cond block state in bits 26:25 and 15:10
// - Monitor 32-bit: store bypass bit 23, access never bit 22, else zero
// - Monitor 32-bit: greater-equal flags in bits 19:16
// - Monitor 32-bit: endianness flag in bit 9
// - After a monitor return in 64-bit state the word is unknown
// - Endianness bit fixed zero or one when an endianness is unsupported
// - Monitor entry from 32-bit sets bit 4 to one
// - Monitor 32-bit mode codes in bits 3:0; other codes reserved
// - Monitor 32-bit masks serror 8, irq 7, fiq 6
`ifndef SAVED_STATUS_DEFINES_SVH
`define SAVED_STATUS_DEFINES_SVH
`define B_N 31
`define B_Q 27
`define B_IT_LO 25
`define B_SSBS32 23
`define B_PAN 22
`define B_SS 21
`define B_IL 20
`define B_GE 16
`define B_SSBS64 12
`define B_IT_HI 10
`define B_D 9
`define B_E 9
`define B_A 8
`define B_I 7
`define B_F 6
`define B_T 5
`define B_NRW 4
`define B_M 0
`define HYP_KEEP_MASK 64'h0000_0000_F070_13DF
`define LOW_HALF_MASK 64'h0000_0000_FFFF_FFFF
`define SP_L0 4'h0
`define SP_L1_SHARED 4'h4
`define SP_L1_OWN 4'h5
`define SP_L2_SHARED 4'h8
`define SP_L2_OWN 4'h9
`define SP_L3_SHARED 4'hC
`define SP_L3_OWN 4'hD
`define MODE_USR 4'h0
`define MODE_FIQ 4'h1
`define MODE_IRQ 4'h2
`define MODE_SVC 4'h3
`define MODE_MON 4'h6
`define MODE_ABT 4'h7
`define MODE_HYP 4'hA
`define MODE_UND 4'hB
`define MODE_SYS 4'hF
`define OP0_SYS 2'h3
`define OP1_SUP 3'h0
`define OP1_HYP 3'h4
`define OP1_MON 3'h6
`define CRN_SPSR 4'h4
`define CRM_SPSR 4'h0
`define OP2_SPSR 3'h0
`endif

// >>> common/saved_status_pkg.sv
// Types shared by the saved status block
package saved_status_pkg;
  typedef enum logic [1:0] {LVL0, LVL1, LVL2, LVL3} level_t;
  typedef enum logic [1:0] {TGT_NONE, TGT_SUP, TGT_HYP, TGT_MON} target_t;
endpackage

// >>> testbench/saved_status_checker_assertions.sv
// Port checks for the saved status block
`timescale 1ns/10ps
`include "saved_status_defines.svh"
module saved_status_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic return_valid,
  input wire logic return_from_mon,
  input wire logic [63:0] restore_word,
  input wire logic restore_narrow,
  input wire logic sysreg_valid,
  input wire logic sysreg_write,
  input wire logic [1:0] sysreg_op0,
  input wire logic [2:0] sysreg_op1,
  input wire logic [3:0] sysreg_crn,
  input wire logic [3:0] sysreg_crm,
  input wire logic [2:0] sysreg_op2,
  input wire logic [63:0] sysreg_wdata,
  input wire logic [1:0] cur_level,
  input wire logic host_mode_control,
  input wire logic supervisor_wr,
  input wire logic [63:0] supervisor_wdata,
  input wire logic [63:0] sysreg_rdata,
  input wire logic sysreg_undef
);
  logic hit, hyp, sup;
  // Other encodings belong elsewhere, so every access check but chk_undef_quiet is gated by a match; the return checks are not
  assign hit = sysreg_valid && sysreg_op0 == `OP0_SYS &&
    sysreg_crn == `CRN_SPSR && sysreg_crm == `CRM_SPSR &&
    sysreg_op2 == `OP2_SPSR;
  assign hyp = hit && sysreg_op1 == `OP1_HYP;
  assign sup = hit && sysreg_op1 == `OP1_SUP;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////
  chk_hyp_low_undef: assert property (
    hyp && cur_level < 2'h2 |-> sysreg_undef)
    else $error("hyp word reached below level 2");
  chk_hyp_high_ok: assert property (
    hyp && cur_level >= 2'h2 |-> !sysreg_undef && !supervisor_wr)
    else $error("hyp word refused at level 2 or 3");
  chk_sup_direct: assert property (
    sup && sysreg_write && cur_level != 2'h0 &&
    !(cur_level == 2'h2 && host_mode_control) |->
    supervisor_wr && supervisor_wdata == sysreg_wdata)
    else $error("supervisor write not passed on");
  chk_sup_redirect: assert property (
    sup && cur_level == 2'h2 && host_mode_control |->
    !supervisor_wr && !sysreg_undef)
    else $error("host mode access not redirected");
  chk_mon_level: assert property (
    hit && sysreg_op1 == `OP1_MON |-> sysreg_undef == (cur_level != 2'h3))
    else $error("monitor word access level wrong");
  chk_undef_quiet: assert property (
    sysreg_undef |-> !supervisor_wr && sysreg_rdata == 64'h0)
    else $error("refused access had an effect");
  chk_hyp_reserved: assert property (
    return_valid && !return_from_mon |=>
    (restore_word & ~`HYP_KEEP_MASK) == 64'h0)
    else $error("hyp reserved bits not zero");
  chk_mon_upper: assert property (
    return_valid && return_from_mon ##1 restore_narrow |->
    restore_word[63:32] == 32'h0)
    else $error("narrow monitor word upper half set");
endmodule
bind saved_status_capture_restore saved_status_checker
  u_saved_status_checker (.*);

// >>> testbench/sup_word_model.sv
// Core-side model of the supervisor saved word
`timescale 1ns/10ps
module sup_word_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic [63:0] wdata,
  output logic [63:0] word_q
);
  // One strobe per edge, so no access under one name overtakes another
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      word_q <= 64'h0;
    else if (wr)
      word_q <= wdata;
endmodule

// >>> testbench/tb_saved_status_capture_restore.sv
// Self-checking bench for the saved status block
`timescale 1ns/10ps
`include "saved_status_defines.svh"
module tb_saved_status_capture_restore;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic entry_valid = 1'b0, entry_to_mon = 1'b0, entry_from_narrow = 1'b0;
  logic return_valid = 1'b0, return_from_mon = 1'b0, host_mode_control = 1'b0;
  logic sysreg_valid = 1'b0, sysreg_write = 1'b0, cur_endian = 1'b0;
  logic cur_store_bypass = 1'b0, cur_priv_access_never = 1'b0;
  logic cur_single_step = 1'b0, cur_illegal_state = 1'b0;
  logic cur_thumb = 1'b0, cur_stack_sel = 1'b0;
  logic [1:0] cur_level = 2'h0;
  logic [2:0] sysreg_op1 = 3'h0;
  logic [1:0] sysreg_op0 = `OP0_SYS;
  logic [3:0] cur_greater_equal = 4'h0, cur_masks = 4'h0;
  logic [3:0] cur_narrow_mode = 4'h0;
  logic [4:0] cur_nzcvq = 5'h00;
  logic [7:0] cur_cond_block = 8'h00;
  logic [63:0] sysreg_wdata = 64'h0, supervisor_saved_status, restore_word;
  logic [63:0] supervisor_wdata, sysreg_rdata, rd;
  logic restore_narrow, restore_illegal, supervisor_wr, sysreg_undef;
  logic [3:0] modes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hA, 4'hB,
    4'hF};
  int n_fail = 0;
  int compares = 0;
  // Op0 alone is varied to show a foreign encoding; CRn, CRm and op2 are tied
  saved_status_capture_restore u_saved_status_capture_restore (
    .sysreg_crn(`CRN_SPSR), .sysreg_crm(`CRM_SPSR), .sysreg_op2(`OP2_SPSR),
    .*);
  sup_word_model u_sup_word_model (.clk, .rst_n, .wr(supervisor_wr),
    .wdata(supervisor_wdata), .word_q(supervisor_saved_status));
  always #10 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic entry(input logic mon, input logic nar);
    entry_valid = 1'b1;
    entry_to_mon = mon;
    entry_from_narrow = nar;
    tick;
    entry_valid = 1'b0;
  endtask
  task automatic ret(input logic mon);
    return_valid = 1'b1;
    return_from_mon = mon;
    tick;
    return_valid = 1'b0;
  endtask
  task automatic acc(input logic w, input logic [2:0] op1,
    input logic [1:0] lv, input logic [63:0] d, input logic u);
    sysreg_valid = 1'b1;
    sysreg_write = w;
    sysreg_op1 = op1;
    cur_level = lv;
    sysreg_wdata = d;
    #2;
    rd = sysreg_rdata;
    check(sysreg_undef, u);
    if (u)
      check(rd, 64'h0);
    tick;
    sysreg_valid = 1'b0;
    tick;
  endtask
  task automatic results;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    // Fields outside the wide layout, all but the narrow mode, are driven high to catch leaks
    cur_nzcvq = 5'h15;
    cur_cond_block = 8'hFF;
    cur_greater_equal = 4'hF;
    {cur_single_step, cur_illegal_state, cur_store_bypass} = 3'h7;
    {cur_endian, cur_thumb, cur_stack_sel} = 3'h7;
    cur_masks = 4'hA;
    cur_level = 2'h1;
    entry(1'b0, 1'b0);
    acc(1'b0, `OP1_HYP, 2'h2, 64'h0, 1'b0);
    check(rd, 64'h0000_0000_A030_1285);
    host_mode_control = 1'b1;
    acc(1'b0, `OP1_SUP, 2'h2, 64'h0, 1'b0);
    check(rd, 64'h0000_0000_A030_1285);
    ret(1'b0);
    check(restore_word, 64'h0000_0000_A030_1285);
    acc(1'b1, `OP1_HYP, 2'h3, '1, 1'b0);
    acc(1'b0, `OP1_HYP, 2'h3, 64'h0, 1'b0);
    check(rd, `HYP_KEEP_MASK);
    for (int i = 0; i < 16; i++)
    begin
      acc(1'b1, `OP1_SUP, 2'h2, 64'(i), 1'b0);
      ret(1'b0);
      check(restore_word, 64'(i));
      check(restore_illegal, !(i inside {0, 4, 5, 8, 9}));
    end
    host_mode_control = 1'b0;
    acc(1'b1, `OP1_SUP, 2'h1, 64'h0000_0000_0000_0055, 1'b0);
    acc(1'b1, `OP1_SUP, 2'h0, 64'h0000_0000_0000_0099, 1'b1);
    acc(1'b0, `OP1_SUP, 2'h2, 64'h0, 1'b0);
    check(rd, 64'h0000_0000_0000_0055);
    for (int lv = 2; lv >= 0; lv--)
    begin
      acc(1'b1, `OP1_HYP, 2'(lv), 64'(lv + 4), lv < 2);
      acc(1'b0, `OP1_HYP, 2'(lv), 64'h0, lv < 2);
      acc(1'b0, `OP1_MON, 2'(lv), 64'h0, 1'b1);
      acc(1'b0, `OP1_SUP, 2'(lv), 64'h0, lv == 0);
    end
    acc(1'b0, `OP1_HYP, 2'h3, 64'h0, 1'b0);
    check(rd, 64'h0000_0000_0000_0006);
    cur_nzcvq = 5'h13;
    cur_cond_block = 8'hB7;
    cur_greater_equal = 4'h5;
    {cur_single_step, cur_illegal_state, cur_store_bypass} = 3'h3;
    cur_priv_access_never = 1'b1;
    cur_masks = 4'h5;
    foreach (modes[i])
    begin
      cur_narrow_mode = modes[i];
      entry(1'b1, 1'b1);
      acc(1'b0, `OP1_MON, 2'h3, 64'h0, 1'b0);
      check(rd, {60'h000_0000_9ED5_B77, modes[i]});
    end
    ret(1'b1);
    check(restore_word, 64'h0000_0000_9ED5_B77F);
    check(restore_narrow, 1'b1);
    acc(1'b1, `OP1_MON, 2'h3, '1, 1'b0);
    acc(1'b0, `OP1_MON, 2'h3, 64'h0, 1'b0);
    check(rd, 64'h0000_0000_FFFF_FFFF);
    acc(1'b1, `OP1_MON, 2'h3, 64'h0000_0000_0000_0015, 1'b0);
    ret(1'b1);
    check(restore_illegal, 1'b1);
    entry(1'b1, 1'b0);
    acc(1'b0, `OP1_MON, 2'h3, 64'h0, 1'b0);
    check(rd, 64'h0000_0000_9050_114D);
    ret(1'b1);
    check(restore_word, 64'h0000_0000_9050_114D);
    check(restore_narrow, 1'b0);
    check(restore_illegal, 1'b0);
    acc(1'b0, `OP1_MON, 2'h3, 64'h0, 1'b0);
    check(rd, 64'h0);
    sysreg_op0 = 2'h2;
    acc(1'b0, `OP1_HYP, 2'h0, 64'h0, 1'b0);
    check(rd, 64'h0);
    results;
  end
endmodule
